/* rtl/scsims_core.sv */
// SCSI initiator message, attention, reset and completion status logic
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ns
module scsims_core
    import scsims_pkg::*;
#(
    parameter int PHASE_TIMEOUT = scsims_pkg::PHASE_CYCLES,
    parameter int RST_PULSE     = scsims_pkg::RST_CYCLES,
    parameter int NTAGS         = 17
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scsiReq,
    input  wire logic        scsiMsg,
    input  wire logic        scsiCd,
    input  wire logic        scsiIo,
    input  wire logic        scsiBsy,
    input  wire logic        scsiSel,
    input  wire logic        scsiRstIn,
    input  wire logic [7:0]  scsiDataIn,
    input  wire logic        scsiParIn,
    output logic             scsiAck,
    output logic             scsiAtn,
    output logic             scsiRstOut,
    output logic [7:0]       scsiDataOut,
    output logic             scsiParOut,
    output logic             scsiDataOe,
    output logic             syncMode
);
    import scsims_pkg::*;

    if (NTAGS < 2 || NTAGS > 32 || RST_PULSE < 1 || PHASE_TIMEOUT < 1) begin
        $error("scsims_core: bad parameter");
    end

    // =========================================================
    // Pin synchronisers
    logic [13:0] pinMeta;
    logic [13:0] pinSync;
    wire  [13:0] pinRaw = {scsiReq, scsiMsg, scsiCd, scsiIo, scsiBsy,
                           scsiSel, scsiRstIn, scsiParIn, scsiDataIn[5:0]};
    logic [1:0]  dataHiMeta;
    logic [1:0]  dataHiSync;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta    <= '0;
            pinSync    <= '0;
            dataHiMeta <= '0;
            dataHiSync <= '0;
        end else begin
            pinMeta    <= pinRaw;
            pinSync    <= pinMeta;
            dataHiMeta <= scsiDataIn[7:6];
            dataHiSync <= dataHiMeta;
        end
    end
    wire       req     = pinSync[13];
    wire [2:0] phase   = pinSync[12:10];
    wire       bsy     = pinSync[9];
    wire       selIn   = pinSync[8];
    wire       rstIn   = pinSync[7];
    wire       parIn   = pinSync[6];
    wire [7:0] dataIn  = {dataHiSync, pinSync[5:0]};
    wire       parBad  = (^{dataIn, parIn}) == 1'b0;
    wire       inMsgIn = phase == PH_MSGIN;
    wire       inMsgOut = phase == PH_MSGOUT;
    wire       inStat  = phase == PH_STATUS;
    wire       nonData = bsy && phase[1];
    wire       reselect = selIn && phase[0] && !bsy;

    // =========================================================
    // Registers
    logic [15:0] status_reg, status_next;
    logic [15:0] statExt_reg, statExt_next;
    logic [2:0]  control_reg;
    logic [15:0] command_reg;
    logic [15:0] event_reg;
    logic [NTAGS-1:0] active_reg;
    logic [15:0] curPtr_reg, savedPtr_reg;
    logic        ackOut_reg, atn_reg, rejPend_reg, ignoreExt_reg;
    logic        mpePend_reg, bdrPend_reg, dropPend_reg, watchMo_reg;
    logic [31:0] phaseCnt_reg;
    logic [31:0] rstCnt_reg;
    logic        rstInPrev_reg, reqPrev_reg;
    logic [7:0]  outMsg_reg;
    logic [7:0]  scsiStat_reg;

    wire apbAccess = psel && penable;
    wire wrEn      = apbAccess && pwrite;
    wire hitStat   = paddr == OFF_STATUS;
    wire hitExt    = paddr == OFF_STATEXT;
    wire hitCtl    = paddr == OFF_CONTROL;
    wire hitCmd    = paddr == OFF_CMD;
    wire hitEvt    = paddr == OFF_EVENT;
    wire hitPh     = paddr == OFF_PHASE;
    wire mapped    = hitStat | hitExt | hitCtl | hitCmd | hitEvt | hitPh;
    wire cmdWrite  = wrEn && hitCmd;
    wire evtWrite  = wrEn && hitEvt;
    wire [3:0] opCode = pwdata[15:12];
    wire [4:0] tagIn  = pwdata[4:0];
    wire [2:0] idIn   = pwdata[10:8];
    wire [3:0] parmIn = pwdata[7:4];
    wire [7:0] evtCode = pwdata[7:0];
    wire [4:0] evtTag  = pwdata[12:8];
    wire [7:0] evtAux  = pwdata[23:16];

    // Command validation
    wire tagBig   = opCode <= 4'h1 ? tagIn > 5'h0f : tagIn > 5'h10;
    wire tagOk    = 32'(tagIn) < NTAGS;
    wire tagBusy  = tagOk && active_reg[tagIn[$clog2(NTAGS)-1:0]];
    wire opBad    = opCode > 4'h8;
    wire cntBad   = opCode == OP_SEND && parmIn != 4'h6
                    && parmIn != 4'ha && parmIn != 4'hc;
    wire idBad    = opCode == OP_SEND && idIn == OWN_ID;
    wire [7:0] rejCode = tagBusy ? 8'h21 : tagBig ? 8'h22 :
                         opBad ? 8'h23 : cntBad ? 8'h24 :
                         idBad ? 8'h25 : 8'h00;
    wire [7:0] tagLow  = {3'h0, tagIn};

    // Message-in handling
    wire reqRise  = req && !reqPrev_reg;
    wire msgByte  = reqRise && inMsgIn && !ackOut_reg;
    wire rpAccept = command_reg[11:8] == 4'h0 || curPtr_reg == savedPtr_reg;
    wire msgKnown = dataIn == MSG_CC || dataIn == MSG_SDP
                    || dataIn == MSG_DSC || dataIn == MSG_MR
                    || dataIn[7] || dataIn == MSG_EXT
                    || (dataIn == MSG_RP && rpAccept);
    wire msgReject = msgByte && !parBad && !msgKnown && !ignoreExt_reg;
    wire phaseTimeout = nonData && phaseCnt_reg == 32'(PHASE_TIMEOUT);
    wire moMissed = watchMo_reg && reqRise && !inMsgOut;
    wire fireRst  = (cmdWrite && opCode == OP_POWER_ON_SELF_TESTS) || phaseTimeout
                    || moMissed;
    wire rstEdge  = rstIn && !rstInPrev_reg;

    // =========================================================
    // Status words
    always_comb begin
        status_next  = status_reg;
        statExt_next = statExt_reg;
        if (rstEdge) begin
            status_next  = {CC_BUSRESET, 3'h0, TAG_FIXED};
        end else if (cmdWrite && rejCode != 8'h00) begin
            status_next  = {rejCode, tagLow};
            statExt_next = pwdata[15:0];
        end else if (cmdWrite && opCode == OP_POWER_ON_SELF_TESTS) begin
            status_next  = {CC_READY, 3'h0, TAG_FIXED};
        end else if (cmdWrite && opCode != OP_SEND) begin
            status_next  = {CC_GOOD, tagLow};
        end else if (msgByte && !parBad && dataIn == MSG_CC) begin
            if (scsiStat_reg == CC_BADSTAT)
                status_next = {CC_BADSTAT, 3'h0, command_reg[4:0]};
            else
                status_next = {scsiStat_reg, 2'h0, 1'b1,
                               command_reg[4:0]};
            statExt_next = curPtr_reg;
        end else if (evtWrite) begin
            if (evtCode == CC_INTERIM && status_reg[15:8] == CC_INTERIM)
                statExt_next = {statExt_reg[15:8] + 8'h01, 8'h00};
            else if (evtCode == CC_INTERIM)
                statExt_next = 16'h0100;
            else if (evtCode == 8'h41 || evtCode == 8'h42
                     || evtCode == 8'h44)
                statExt_next = {evtAux, EXT_LOW_OK};
            else if (evtCode == CC_WATCHDOG || evtCode == CC_WILDBR)
                statExt_next = pwdata[31:16];
            if (evtCode[7] && !evtCode[5])
                status_next = {evtCode, 3'h0, TAG_FIXED};
            else if (evtCode[7:5] == CLS_BATFAIL)
                status_next = {evtCode, 3'h0, TAG_FIXED};
            else
                status_next = {evtCode, 3'h0, evtTag};
        end
    end

    // =========================================================
    // State and bus handshake
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg   <= {CC_READY, 3'h0, TAG_FIXED};
            statExt_reg  <= '0;
            control_reg  <= '0;
            command_reg  <= '0;
            event_reg    <= '0;
            active_reg   <= '0;
            curPtr_reg   <= '0;
            savedPtr_reg <= '0;
            ackOut_reg   <= 1'b0;
            atn_reg      <= 1'b0;
            rejPend_reg  <= 1'b0;
            ignoreExt_reg <= 1'b0;
            mpePend_reg  <= 1'b0;
            bdrPend_reg  <= 1'b0;
            dropPend_reg <= 1'b0;
            watchMo_reg  <= 1'b0;
            phaseCnt_reg <= '0;
            rstCnt_reg   <= '0;
            rstInPrev_reg <= 1'b0;
            reqPrev_reg  <= 1'b0;
            outMsg_reg   <= MSG_NOP;
            scsiStat_reg <= '0;
        end else begin
            status_reg    <= status_next;
            statExt_reg   <= statExt_next;
            rstInPrev_reg <= rstIn;
            reqPrev_reg   <= req;
            if (wrEn && hitCtl)
                control_reg <= pwdata[2:0];
            if (evtWrite)
                event_reg <= pwdata[15:0];
            if (cmdWrite && rejCode == 8'h00) begin
                command_reg <= pwdata[15:0];
                if (opCode == OP_SEND && tagOk)
                    active_reg[tagIn[$clog2(NTAGS)-1:0]] <= 1'b1;
            end
            if (rstEdge)
                active_reg <= '0;
            // Phase watchdog
            if (!nonData || reqRise)
                phaseCnt_reg <= '0;
            else
                phaseCnt_reg <= phaseCnt_reg + 32'd1;
            // Reset pulse generator
            if (fireRst)
                rstCnt_reg <= 32'(RST_PULSE);
            else if (rstCnt_reg != '0)
                rstCnt_reg <= rstCnt_reg - 32'd1;
            // Track data pointer
            if (reqRise && !phase[1] && bsy)
                curPtr_reg <= curPtr_reg + 16'h0001;
            // Incoming byte handshake
            if (reqRise && !ackOut_reg && bsy) begin
                ackOut_reg <= 1'b1;
                if (inStat)
                    scsiStat_reg <= parBad ? CC_BADSTAT : dataIn;
                if (inMsgIn) begin
                    if (parBad) begin
                        mpePend_reg <= 1'b1;
                        outMsg_reg  <= MSG_MPE;
                        atn_reg     <= 1'b1;
                    end else if (msgReject) begin
                        rejPend_reg   <= 1'b1;
                        ignoreExt_reg <= 1'b1;
                        outMsg_reg    <= MSG_MR;
                        atn_reg       <= 1'b1;
                    end else if (dataIn == MSG_SDP) begin
                        savedPtr_reg <= curPtr_reg;
                    end else if (dataIn == MSG_RP) begin
                        curPtr_reg <= savedPtr_reg;
                    end else if (dataIn == MSG_CC) begin
                        active_reg[command_reg[$clog2(NTAGS)-1:0]]
                            <= 1'b0;
                    end
                end
            end else if (!req && ackOut_reg) begin
                ackOut_reg <= 1'b0;
                if (mpePend_reg || rejPend_reg || bdrPend_reg)
                    watchMo_reg <= 1'b1;
            end
            if (inMsgOut) begin
                watchMo_reg <= 1'b0;
                // Last byte: drop attention while REQ high, ACK low
                if (req && !ackOut_reg && atn_reg) begin
                    atn_reg      <= 1'b0;
                    dropPend_reg <= 1'b1;
                end
            end
            if (moMissed && bdrPend_reg)
                active_reg <= '0;
            if (dropPend_reg && !inMsgOut) begin
                dropPend_reg  <= 1'b0;
                mpePend_reg   <= 1'b0;
                rejPend_reg   <= 1'b0;
                bdrPend_reg   <= 1'b0;
                ignoreExt_reg <= 1'b0;
                outMsg_reg    <= MSG_NOP;
            end
            // Reselection while no command is live on any tag
            if (reselect && active_reg == '0) begin
                bdrPend_reg <= 1'b1;
                outMsg_reg  <= MSG_BDR;
                atn_reg     <= 1'b1;
            end
            if (wrEn && hitCtl && pwdata[CTL_MSGOUT])
                atn_reg <= 1'b1;
            if (moMissed)
                watchMo_reg <= 1'b0;
        end
    end

    // =========================================================
    // Outputs and APB read
    wire [31:0] rdMux = hitStat ? {16'h0, status_reg} :
                        hitExt  ? {16'h0, statExt_reg} :
                        hitCtl  ? {29'h0, control_reg} :
                        hitCmd  ? {16'h0, command_reg} :
                        hitEvt  ? {16'h0, event_reg} :
                        hitPh   ? {24'h0, outMsg_reg} : 32'h0;
    wire [7:0] txByte = inMsgOut ? outMsg_reg : 8'h00;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata      <= '0;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            scsiAck     <= 1'b0;
            scsiAtn     <= 1'b0;
            scsiRstOut  <= 1'b0;
            scsiDataOut <= '0;
            scsiParOut  <= 1'b1;
            scsiDataOe  <= 1'b0;
            syncMode    <= 1'b0;
        end else begin
            pready      <= psel && !penable;
            pslverr     <= psel && !penable && !mapped;
            prdata      <= (psel && !penable && !pwrite) ? rdMux : 32'h0;
            scsiAck     <= ackOut_reg;
            scsiAtn     <= atn_reg;
            scsiRstOut  <= rstCnt_reg != '0;
            scsiDataOut <= txByte;
            scsiParOut  <= ~^txByte;
            scsiDataOe  <= bsy && !phase[0];
            syncMode    <= control_reg[CTL_SYNCOK];
        end
    end
endmodule

/* rtl/scsims_pkg.sv */
// Package of constants for the SCSI initiator message and status block
package scsims_pkg;
    // =========================================================
    // Register map
    localparam logic [11:0] OFF_STATUS   = 12'h000;
    localparam logic [11:0] OFF_STATEXT  = 12'h004;
    localparam logic [11:0] OFF_CONTROL  = 12'h008;
    localparam logic [11:0] OFF_CMD      = 12'h00c;
    localparam logic [11:0] OFF_EVENT    = 12'h010;
    localparam logic [11:0] OFF_PHASE    = 12'h014;
    // Control bit positions
    localparam int CTL_REPORT  = 0;
    localparam int CTL_SYNCOK  = 1;
    localparam int CTL_MSGOUT  = 2;
    // =========================================================
    // Completion codes
    localparam logic [7:0] CC_READY     = 8'h0f;
    localparam logic [7:0] CC_DIFFSENSE = 8'h81;
    localparam logic [7:0] CC_TERMPWR   = 8'h82;
    localparam logic [7:0] CC_BUSRESET  = 8'h83;
    localparam logic [7:0] CC_WATCHDOG  = 8'h84;
    localparam logic [7:0] CC_WILDBR    = 8'h88;
    localparam logic [7:0] CC_GOOD      = 8'h00;
    localparam logic [7:0] CC_INTERIM   = 8'ha1;
    localparam logic [2:0] CLS_BATFAIL  = 3'h6;
    localparam logic [2:0] CLS_WRAPFAIL = 3'h7;
    localparam logic [4:0] TAG_FIXED    = 5'h1f;
    localparam int         LOW_SCSI_BIT = 5;
    localparam logic [7:0] EXT_LOW_OK   = 8'h20;
    localparam logic [7:0] CC_BADSTAT   = 8'h48;
    // Host op codes
    localparam logic [3:0] OP_SEND  = 4'h0;
    localparam logic [3:0] OP_POWER_ON_SELF_TESTS  = 4'h4;
    // Message codes
    localparam logic [7:0] MSG_CC    = 8'h00;
    localparam logic [7:0] MSG_EXT   = 8'h01;
    localparam logic [7:0] MSG_SDP   = 8'h02;
    localparam logic [7:0] MSG_RP    = 8'h03;
    localparam logic [7:0] MSG_DSC   = 8'h04;
    localparam logic [7:0] MSG_IDE   = 8'h05;
    localparam logic [7:0] MSG_MR    = 8'h07;
    localparam logic [7:0] MSG_NOP   = 8'h08;
    localparam logic [7:0] MSG_MPE   = 8'h09;
    localparam logic [7:0] MSG_BDR   = 8'h0c;
    localparam logic [7:0] MSG_SYNC  = 8'h01;
    // Bus identity
    localparam logic [2:0] OWN_ID = 3'h7;
    // =========================================================
    // Timing
    localparam int CLK_MHZ       = 250;
    localparam int PHASE_LIMIT_MS = 65;
    localparam int PHASE_CYCLES  = PHASE_LIMIT_MS * 1000 * CLK_MHZ;
    localparam int RST_PULSE_US  = 25;
    localparam int RST_CYCLES    = RST_PULSE_US * CLK_MHZ;
    // Bus phases seen on msg, cd, io
    typedef enum logic [2:0] {
        PH_DATAOUT = 3'h0, PH_DATAIN = 3'h1, PH_CMD = 3'h2,
        PH_STATUS  = 3'h3, PH_MSGOUT = 3'h6, PH_MSGIN = 3'h7
    } scsims_phase_e;
endpackage

/* test/scsims_core_asserts.sv */
// Concurrent checks on the ports of the SCSI message and status core
`timescale 1ns/1ns
module scsims_core_asserts #(
    parameter int PHASE_TIMEOUT = 200,
    parameter int RST_PULSE     = 8,
    parameter int NTAGS         = 17
) (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        scsiReq,
    input wire logic        scsiMsg,
    input wire logic        scsiCd,
    input wire logic        scsiIo,
    input wire logic        scsiBsy,
    input wire logic [7:0]  scsiDataIn,
    input wire logic        scsiParIn,
    input wire logic        scsiAck,
    input wire logic        scsiAtn,
    input wire logic        scsiRstOut,
    input wire logic [7:0]  scsiDataOut,
    input wire logic        scsiParOut,
    input wire logic        scsiDataOe
);
    import scsims_pkg::*;
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ====================
    // Helper logic
    wire [2:0] phase   = {scsiMsg, scsiCd, scsiIo};
    wire       inOk    = scsiDataIn[7] || scsiDataIn inside
        {MSG_CC, MSG_EXT, MSG_SDP, MSG_RP, MSG_DSC, MSG_MR};
    wire       badIn   = scsiReq && phase == 3'h7 &&
        !(^{scsiDataIn, scsiParIn} && inOk);
    wire       nonData = scsiBsy && phase[1] && !scsiRstOut;
    logic       needAtn;
    logic [2:0] lastPh;
    int         phCnt;
    int         rstCnt;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) needAtn <= 1'b0;
        else if (badIn) needAtn <= 1'b1;
        else if (!scsiAck && !scsiReq) needAtn <= 1'b0;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) lastPh <= 3'h0;
        else lastPh <= phase;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) phCnt <= 0;
        else if (!nonData || phase != lastPh) phCnt <= 0;
        else phCnt <= phCnt + 1;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) rstCnt <= 0;
        else rstCnt <= scsiRstOut ? rstCnt + 1 : 0;
    end
    sequence cmdWrite;
        psel && penable && pready && pwrite && paddr == OFF_CMD;
    endsequence
    sequence selfTestOp;
        cmdWrite ##0 pwdata[15:12] == OP_POWER_ON_SELF_TESTS;
    endsequence
    // ====================
    // Assertions
    AST_PREADY_SETUP: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    AST_SLVERR_MAP: assert property (pready |->
        pslverr == (paddr > OFF_PHASE) && (!pslverr || prdata == 32'h0))
        else $error("error response wrong for address");
    AST_SELFTEST_RST: assert property (
        selfTestOp |-> ##[1:16] scsiRstOut)
        else $error("self-test gave no bus reset");
    AST_RST_PULSE_LEN: assert property (
        $fell(scsiRstOut) |-> rstCnt == RST_PULSE)
        else $error("bus reset pulse length wrong");
    AST_PHASE_TIMEOUT: assert property (
        phCnt == PHASE_TIMEOUT |-> ##[0:12] scsiRstOut)
        else $error("long phase gave no bus reset");
    AST_NEED_ATN: assert property (
        $fell(scsiAck) && needAtn |-> $past(scsiAtn))
        else $error("attention late for bad message byte");
    AST_ATN_DROP: assert property (
        $fell(scsiAtn) && phase == 3'h6 |->
        $past(scsiReq) && !$past(scsiAck))
        else $error("attention dropped outside last handshake");
    AST_ACK_AFTER_REQ: assert property (
        $rose(scsiAck) |-> $past(scsiReq, 2))
        else $error("ack without request");
    AST_ACK_HOLD: assert property (scsiAck && scsiReq |=> scsiAck)
        else $error("ack released while request high");
    AST_OUT_PARITY: assert property (
        scsiDataOe |-> ^{scsiDataOut, scsiParOut})
        else $error("outgoing parity not odd");
endmodule

/* test/scsims_target.sv */
// Behavioural SCSI target on the far side of the bus
`timescale 1ns/1ns
module scsims_target (
    input  wire logic       core_clk,
    input  wire logic       scsiAck,
    input  wire logic       scsiAtn,
    input  wire logic [7:0] scsiDataOut,
    output logic            scsiReq,
    output logic            scsiMsg,
    output logic            scsiCd,
    output logic            scsiIo,
    output logic            scsiBsy,
    output logic            scsiSel,
    output logic            scsiRstIn,
    output logic [7:0]      scsiDataIn,
    output logic            scsiParIn
);
    int hangs = 0;
    initial begin
        {scsiReq, scsiMsg, scsiCd, scsiIo, scsiBsy, scsiSel} = 6'h0;
        scsiRstIn = 1'b0;
        scsiDataIn = 8'h5a;
        scsiParIn = 1'b0;
    end
    // ====================
    // Handshake tasks
    task automatic waitAck(input logic lvl);
        int n = 0;
        while (scsiAck !== lvl && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 100) hangs++;
    endtask
    task automatic setPhase(input logic [2:0] ph, input logic bsy);
        @(posedge core_clk);
        {scsiMsg, scsiCd, scsiIo} <= ph;
        scsiBsy <= bsy;
    endtask
    task automatic busFree();
        setPhase(3'h0, 1'b0);
    endtask
    task automatic sendIn(input logic [7:0] d, input logic bad,
                          output logic atnHeld);
        int n = 0;
        setPhase(3'h7, 1'b1);
        scsiDataIn <= d;
        scsiParIn <= ~^d ^ bad;
        @(posedge core_clk);
        scsiReq <= 1'b1;
        waitAck(1'b1);
        scsiReq <= 1'b0;
        do begin
            atnHeld = scsiAtn;
            @(posedge core_clk);
            n++;
        end while (scsiAck === 1'b1 && n < 100);
        if (n >= 100) hangs++;
        scsiDataIn <= ~d;
        scsiParIn <= ~scsiParIn;
    endtask
    task automatic takeOut(output logic [7:0] d, output logic atnAtAck);
        setPhase(3'h6, 1'b1);
        @(posedge core_clk);
        scsiReq <= 1'b1;
        waitAck(1'b1);
        d = scsiDataOut;
        atnAtAck = scsiAtn;
        scsiReq <= 1'b0;
        waitAck(1'b0);
    endtask
    task automatic pulseRst();
        @(posedge core_clk);
        scsiRstIn <= 1'b1;
        repeat (4) @(posedge core_clk);
        scsiRstIn <= 1'b0;
    endtask
endmodule

/* test/scsi_initiator_msg_status_bench.sv */
// Self-checking testbench for the SCSI message and status core
`timescale 1ns/1ns
module scsi_initiator_msg_status_bench;
    import scsims_pkg::*;
    localparam int PT = 200;
    localparam int RP = 8;
    logic        core_clk, rst_n, psel, penable, pwrite;
    logic        pready, pslverr, syncMode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        scsiReq, scsiMsg, scsiCd, scsiIo, scsiBsy, scsiSel;
    logic        scsiRstIn, scsiParIn, scsiAck, scsiAtn, scsiRstOut;
    logic        scsiParOut, scsiDataOe;
    logic [7:0]  scsiDataIn, scsiDataOut;
    int          mismatches = 0;
    int          cmp_count = 0;
    scsims_core #(.PHASE_TIMEOUT(PT), .RST_PULSE(RP)) scsims_core_i (
        .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .scsiReq, .scsiMsg, .scsiCd, .scsiIo,
        .scsiBsy, .scsiSel, .scsiRstIn, .scsiDataIn, .scsiParIn, .scsiAck,
        .scsiAtn, .scsiRstOut, .scsiDataOut, .scsiParOut, .scsiDataOe,
        .syncMode);
    scsims_target scsims_target_i (
        .core_clk, .scsiAck, .scsiAtn, .scsiDataOut, .scsiReq, .scsiMsg,
        .scsiCd, .scsiIo, .scsiBsy, .scsiSel, .scsiRstIn, .scsiDataIn,
        .scsiParIn);
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // ====================
    // Shared tasks
    task automatic final_report();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic readChk(input string what, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, OFF_STATUS, 32'h0, rd, err);
        check(what, rd, exp);
    endtask
    task automatic rstPulse(input int lim, output int len);
        int n = 0;
        len = 0;
        while (scsiRstOut !== 1'b1 && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        while (scsiRstOut === 1'b1 && len < 1000) begin
            @(posedge core_clk);
            len++;
        end
    endtask
    task automatic msgFault(input logic [7:0] d, input logic bad,
                            input logic [7:0] expMsg);
        logic       atn;
        logic [7:0] m;
        scsims_target_i.sendIn(d, bad, atn);
        check("attention before ack release", atn, 1'b1);
        scsims_target_i.takeOut(m, atn);
        check("outgoing message", m, expMsg);
        check("attention at last handshake", atn, 1'b0);
        scsims_target_i.busFree();
    endtask
    // ====================
    // Scenarios
    task automatic testReset();
        logic [31:0] rd;
        logic        err;
        readChk("status after reset", 32'h0000_0f1f);
        apb(1'b0, 12'h100, 32'h0, rd, err);
        check("unmapped error", err, 1'b1);
        check("unmapped data", rd, 32'h0);
        apb(1'b1, OFF_STATUS, 32'hffff_ffff, rd, err);
        apb(1'b1, OFF_CONTROL, 32'h2, rd, err);
        readChk("status is read only", 32'h0000_0f1f);
        check("sync mode", syncMode, 1'b1);
    endtask
    task automatic testSelfTest();
        logic [31:0] rd;
        logic        err;
        int          len;
        apb(1'b1, OFF_CMD, {16'h0, OP_POWER_ON_SELF_TESTS, 12'h000}, rd, err);
        rstPulse(20, len);
        check("self-test reset pulse", len, RP);
        readChk("status after self-test", 32'h0000_0f1f);
    endtask
    task automatic testBusReset();
        scsims_target_i.pulseRst();
        repeat (6) @(posedge core_clk);
        readChk("status after bus reset", 32'h0000_831f);
    endtask
    task automatic testAccept();
        logic [7:0] codes [6] = '{MSG_SDP, MSG_RP, MSG_MR, 8'h80,
                                  MSG_CC, MSG_DSC};
        logic       atn;
        foreach (codes[i]) begin
            scsims_target_i.sendIn(codes[i], 1'b0, atn);
            check("no attention on accepted", atn, 1'b0);
        end
        scsims_target_i.busFree();
        readChk("complete status", 32'h0000_0020);
    endtask
    task automatic testTimeout();
        int len;
        scsims_target_i.setPhase(3'h3, 1'b1);
        rstPulse(PT + 40, len);
        check("phase timeout reset pulse", len, RP);
        scsims_target_i.busFree();
    endtask
    initial begin
        {rst_n, psel, penable, pwrite} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        testReset();
        testSelfTest();
        testBusReset();
        msgFault(MSG_CC, 1'b1, MSG_MPE);
        msgFault(8'h06, 1'b0, MSG_MR);
        testAccept();
        testTimeout();
        check("target handshake hangs", scsims_target_i.hangs, 32'h0);
        final_report();
    end
endmodule
bind scsims_core scsims_core_asserts #(
    .PHASE_TIMEOUT(PHASE_TIMEOUT), .RST_PULSE(RST_PULSE), .NTAGS(NTAGS)
) scsims_core_asserts_i (
    .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .scsiReq, .scsiMsg, .scsiCd, .scsiIo, .scsiBsy,
    .scsiDataIn, .scsiParIn, .scsiAck, .scsiAtn, .scsiRstOut, .scsiDataOut,
    .scsiParOut, .scsiDataOe);
